// file: core/bisl_params.svh
// constants and behaviour notes for the board interrupt source logic
// Notes on behaviour
// [RULE1] host bus write sets on-board flag request
// [RULE2] on-board write drives selectable bus interrupt
// [RULE3] timeout on grant wait or acknowledge wait
// [RULE4] pulsed event latched as level request
// [RULE5] OR of up to four jumpered sources
// [RULE6] NOR of up to two jumpered sources
// [RULE7] ring indicator channels four-seven latched
// [RULE8] eight bus interrupt lines accepted
// [RULE9] thirty-two serial controller causes gathered
// [RULE10] five processor timer and DMA sources
// [RULE11] three companion timer sources
// [RULE12] two lines plus DMA per connector
// [RULE13] latches hold until explicit clear
// [RULE14] bus flag holds until host clears
`ifndef BISL_PARAMS_SVH
`define BISL_PARAMS_SVH
// -----------------------------------------------------------------------------
// counts and timing
// -----------------------------------------------------------------------------
`define BISL_BUS_LINES        8
`define BISL_SERIAL_CAUSES    32
`define BISL_CPU_SOURCES      5
`define BISL_COMP_SOURCES     3
`define BISL_CONNECTORS       2
`define BISL_OR_INPUTS        4
`define BISL_NOR_INPUTS       2
`define BISL_RI_CHANNELS      4
`define BISL_CLK_PERIOD_NS    10
`define BISL_TIMEOUT_NS       10000
`define BISL_TIMEOUT_CYC      (`BISL_TIMEOUT_NS / `BISL_CLK_PERIOD_NS)
`define BISL_CNT_W            16
`endif

// file: core/bisl_pkg.sv
// types for the board interrupt source logic
package bisl_pkg;
  typedef enum logic [2:0] {
    BISL_IDLE = 3'b001,
    BISL_WAIT = 3'b010,
    BISL_TOUT = 3'b100
  } bisl_fs_e;

  typedef struct packed {
    logic       host_set;
    logic       host_clr;
    logic       cpu_set;
    logic       cpu_clr;
    logic [2:0] bus_sel;
  } bisl_flag_s;

  typedef struct packed {
    logic req;
    logic grant;
    logic cycle;
    logic ack;
    logic clr;
  } bisl_bus_s;
endpackage

// file: core/bisl_top.sv
// board interrupt source gathering, latching and flag-byte handshake
`timescale 1ns/1ps
`include "bisl_params.svh"
module bisl_top
  import bisl_pkg::*;
#(
  parameter int TIMEOUT_CYC = `BISL_TIMEOUT_CYC
)(
  input  wire logic                             mclk,
  input  wire logic                             rst_n,
  input  wire bisl_flag_s                       flag,
  input  wire bisl_bus_s                        bus,
  input  wire logic                             pulse_evt,
  input  wire logic                             pulse_clr,
  input  wire logic [`BISL_RI_CHANNELS-1:0]     ring_in,
  input  wire logic                             ring_clr,
  input  wire logic [`BISL_OR_INPUTS-1:0]       or_src,
  input  wire logic [`BISL_OR_INPUTS-1:0]       or_jumper,
  input  wire logic [`BISL_NOR_INPUTS-1:0]      nor_src,
  input  wire logic [`BISL_NOR_INPUTS-1:0]      nor_jumper,
  input  wire logic [`BISL_BUS_LINES-1:0]       bus_irq_n,
  input  wire logic [`BISL_SERIAL_CAUSES-1:0]   serial_irq,
  input  wire logic [`BISL_CPU_SOURCES-1:0]     cpu_irq,
  input  wire logic [`BISL_COMP_SOURCES-1:0]    comp_irq,
  input  wire logic [2*`BISL_CONNECTORS-1:0]    exp_irq,
  input  wire logic [`BISL_CONNECTORS-1:0]      expansion_dma_terminal_irq,
  output logic                                  flag_irq,
  output logic [`BISL_BUS_LINES-1:0]            bus_irq_out,
  output logic [`BISL_BUS_LINES-1:0]            bus_irq_oe_n,
  output logic                                  timeout_irq,
  output logic                                  pulse_irq,
  output logic                                  ring_irq,
  output logic                                  or_irq,
  output logic                                  nor_irq_n,
  output logic [`BISL_BUS_LINES-1:0]            bus_req,
  output logic [`BISL_SERIAL_CAUSES-1:0]        serial_req,
  output logic [`BISL_CPU_SOURCES-1:0]          cpu_req,
  output logic [`BISL_COMP_SOURCES-1:0]         comp_req,
  output logic [2*`BISL_CONNECTORS-1:0]         exp_req,
  output logic [`BISL_CONNECTORS-1:0]           exp_dma_req
);
  // ---------------------------------------------------------------------------
  // latch inputs: set wins over clear so no event is lost
  // ---------------------------------------------------------------------------
  logic                         bus_flag;
  logic [`BISL_RI_CHANNELS-1:0] ring_d;
  logic                         pulse_d;
  wire                          next_flag_irq;
  wire                          next_bus_flag;
  wire                          pulse_rise;
  wire                          ring_rise;
  wire                          next_pulse_irq;
  wire                          next_ring_irq;

  assign next_flag_irq  = flag.host_set | (flag_irq & ~flag.cpu_clr);      // [RULE1] [RULE13]
  assign next_bus_flag  = flag.cpu_set | (bus_flag & ~flag.host_clr);      // [RULE2] [RULE14]
  assign pulse_rise     = pulse_evt & ~pulse_d;
  assign next_pulse_irq = pulse_rise | (pulse_irq & ~pulse_clr);           // [RULE4] [RULE13]
  assign ring_rise      = |(ring_in & ~ring_d);
  assign next_ring_irq  = ring_rise | (ring_irq & ~ring_clr);              // [RULE7] [RULE13]

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      flag_irq  <= 1'b0;
      bus_flag  <= 1'b0;
      pulse_d   <= 1'b0;
      pulse_irq <= 1'b0;
      ring_d    <= '0;
      ring_irq  <= 1'b0;
    end else begin
      flag_irq  <= next_flag_irq;
      bus_flag  <= next_bus_flag;
      pulse_d   <= pulse_evt;
      pulse_irq <= next_pulse_irq;
      ring_d    <= ring_in;
      ring_irq  <= next_ring_irq;
    end
  end

  // ---------------------------------------------------------------------------
  // bus flag line select: open-drain, enable low while pulling the line
  // ---------------------------------------------------------------------------
  logic [2:0] bus_sel;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      bus_sel <= 3'h0;
    end else if (flag.cpu_set) begin
      bus_sel <= flag.bus_sel;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < `BISL_BUS_LINES; gi++) begin : g_line
      assign bus_irq_out[gi]  = 1'b0;
      assign bus_irq_oe_n[gi] = ~(bus_flag && (bus_sel == 3'(gi)));        // [RULE2]
    end
  endgenerate

  // ---------------------------------------------------------------------------
  // fail-safe timeout watching grant wait and acknowledge wait
  // ---------------------------------------------------------------------------
  localparam logic [`BISL_CNT_W-1:0] TOUT_LIM = (`BISL_CNT_W)'(TIMEOUT_CYC - 1);
  bisl_fs_e              fs;
  bisl_fs_e              next_fs;
  logic [`BISL_CNT_W-1:0] cnt;
  wire                   waiting;
  wire                   expired;

  // either wait kind counts; a grant that arrives during a cycle restarts nothing
  assign waiting = (bus.req & ~bus.grant) | (bus.cycle & ~bus.ack);        // [RULE3]
  assign expired = (cnt == TOUT_LIM);

  always_comb begin
    next_fs = fs;
    case (fs)
      BISL_IDLE: begin
        if (waiting) begin
          next_fs = BISL_WAIT;
        end
      end
      BISL_WAIT: begin
        if (!waiting) begin
          next_fs = BISL_IDLE;
        end else if (expired) begin
          next_fs = BISL_TOUT;                                             // [RULE3]
        end
      end
      BISL_TOUT: begin
        if (bus.clr && !waiting) begin
          next_fs = BISL_IDLE;                                             // [RULE13]
        end
      end
      default: next_fs = BISL_IDLE;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      fs          <= BISL_IDLE;
      cnt         <= '0;
      timeout_irq <= 1'b0;
    end else begin
      fs          <= next_fs;
      cnt         <= (next_fs == BISL_WAIT && fs == BISL_WAIT) ? cnt + 1'b1 : '0;
      timeout_irq <= (next_fs == BISL_TOUT);                               // [RULE3]
    end
  end

  // ---------------------------------------------------------------------------
  // concentrators and straight-through sources, registered
  // ---------------------------------------------------------------------------
  wire next_or  = |(or_src & or_jumper);                                   // [RULE5]
  wire next_nor = ~|(nor_src & nor_jumper);                                // [RULE6]

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      or_irq      <= 1'b0;
      nor_irq_n   <= 1'b1;
      bus_req     <= '0;
      serial_req  <= '0;
      cpu_req     <= '0;
      comp_req    <= '0;
      exp_req     <= '0;
      exp_dma_req <= '0;
    end else begin
      or_irq      <= next_or;
      nor_irq_n   <= next_nor;
      bus_req     <= ~bus_irq_n;                                           // [RULE8]
      serial_req  <= serial_irq;                                           // [RULE9]
      cpu_req     <= cpu_irq;                                              // [RULE10]
      comp_req    <= comp_irq;                                             // [RULE11]
      exp_req     <= exp_irq;                                              // [RULE12]
      exp_dma_req <= expansion_dma_terminal_irq;                           // [RULE12]
    end
  end
endmodule

// file: verif/bisl_host_model.sv
// host board model: wired bus interrupt lines and flag service
`timescale 1ns/1ps
module bisl_host_model (
  input  wire logic       mclk,
  input  wire logic       svc_en,
  input  wire logic [7:0] oe_n,
  input  wire logic [7:0] ext_n,
  output logic [7:0]      bus_irq_n,
  output logic            hclr = 1'b0
);
  int wait_cnt = 0;
  // pull-up: a line reads low only while some party pulls it
  assign bus_irq_n = oe_n & ext_n;
  // slow service on purpose, so the bus flag must hold meanwhile
  always @(posedge mclk) begin
    hclr <= #1 1'b0;
    if (svc_en && !(&oe_n)) begin
      wait_cnt++;
      if (wait_cnt == 4) begin
        hclr <= #1 1'b1;
        wait_cnt = 0;
      end
    end else
      wait_cnt = 0;
  end
endmodule

// file: verif/bisl_top_asserts.sv
// assertion checker for the board interrupt source logic
`timescale 1ns/1ps
module bisl_top_asserts
  import bisl_pkg::*;
(
  input wire logic       mclk,
  input wire logic       rst_n,
  input wire bisl_flag_s flag,
  input wire bisl_bus_s  bus,
  input wire logic       pulse_evt,
  input wire logic [3:0] ring_in,
  input wire logic [3:0] or_src,
  input wire logic [3:0] or_jumper,
  input wire logic       flag_irq,
  input wire logic [7:0] bus_irq_oe_n,
  input wire logic       timeout_irq,
  input wire logic       pulse_irq,
  input wire logic       ring_irq,
  input wire logic       or_irq
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  host_flag_a: assert property (flag.host_set |=> flag_irq)
    else $error("host flag not raised");
  flag_hold_a: assert property (flag_irq && !flag.cpu_clr |=> flag_irq)
    else $error("flag dropped early");
  bus_sel_a: assert property (flag.cpu_set |=>
    bus_irq_oe_n == ~(8'h01 << $past(flag.bus_sel))) else $error("bus line wrong");
  bus_hold_a: assert property (!(&bus_irq_oe_n) && !flag.host_clr && !flag.cpu_set
    |=> $stable(bus_irq_oe_n)) else $error("bus flag moved");
  wait_tout_a: assert property (((bus.req && !bus.grant) || (bus.cycle && !bus.ack)) [*8]
    |-> ##[0:4] timeout_irq) else $error("no timeout");
  pulse_lat_a: assert property ($rose(pulse_evt) |=> pulse_irq)
    else $error("pulse not latched");
  ring_lat_a: assert property ((ring_in & ~$past(ring_in)) != 4'h0 |=> ring_irq)
    else $error("ring not latched");
  or_merge_a: assert property (1'b1 |=>
    or_irq == (|($past(or_src) & $past(or_jumper)))) else $error("or merge wrong");
  cover property (flag.cpu_set);
  cover property ($rose(timeout_irq));
  cover property ($rose(ring_irq));
endmodule

// file: verif/tb.sv
// self-checking bench for the board interrupt source logic
`timescale 1ns/1ps
module tb;
  import bisl_pkg::*;
  logic mclk = 1'b0, rst_n = 1'b0, pe = 1'b0, pc = 1'b0, rc = 1'b0, svc = 1'b0;
  bisl_flag_s fl = '0;
  bisl_bus_s bs = '0;
  logic [3:0] ri = 4'h0, os = 4'h0, oj = 4'h0, ex = 4'h0;
  logic [1:0] ns = 2'h0, nj = 2'h0, dm = 2'h0;
  logic [7:0] ext_n = 8'hFF, bin_n, oe_n, breq, pv;
  logic [31:0] si = 32'h0, sr;
  logic [4:0] ci = 5'h0, cr;
  logic [2:0] ki = 3'h0, kr;
  logic [3:0] er;
  logic [1:0] dr;
  logic flag_irq, tout, pirq, rirq, oirq, nirq_n, hclr;
  int error_cnt = 0, checks = 0;
  // or_src, or_jumper, nor_src, nor_jumper, then or_irq, nor_irq_n
  logic [13:0] rows [4] = '{14'h3C31, 14'h2216, 14'h1E25, 14'h07EE};
  bisl_host_model i_bisl_host_model (.mclk(mclk), .svc_en(svc), .oe_n(oe_n),
    .ext_n(ext_n), .bus_irq_n(bin_n), .hclr(hclr));
  bisl_top #(.TIMEOUT_CYC(8)) i_bisl_top (.mclk(mclk), .rst_n(rst_n),
    .flag(bisl_flag_s'(fl | {1'b0, hclr, 5'h00})), .bus(bs), .pulse_evt(pe),
    .pulse_clr(pc), .ring_in(ri), .ring_clr(rc), .or_src(os), .or_jumper(oj),
    .nor_src(ns), .nor_jumper(nj), .bus_irq_n(bin_n), .serial_irq(si), .cpu_irq(ci),
    .comp_irq(ki), .exp_irq(ex), .expansion_dma_terminal_irq(dm), .flag_irq(flag_irq),
    .bus_irq_out(), .bus_irq_oe_n(oe_n), .timeout_irq(tout), .pulse_irq(pirq),
    .ring_irq(rirq), .or_irq(oirq), .nor_irq_n(nirq_n), .bus_req(breq),
    .serial_req(sr), .cpu_req(cr), .comp_req(kr), .exp_req(er), .exp_dma_req(dr));
  task automatic chk(logic [63:0] got, logic [63:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic step(int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic wrap_up;
    if (error_cnt == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial forever #5 mclk = ~mclk;
  initial begin
    #20000;
    error_cnt++;
    wrap_up;
  end
  initial begin
    step(12);
    chk({flag_irq, oe_n, nirq_n, tout}, {1'b0, 8'hFF, 1'b1, 1'b0});
    rst_n = 1'b1;
    step(1);
    for (int i = 0; i < 4; i++) begin
      pv = 8'h01 << i;
      {os, oj, ns, nj} = rows[i][13:2];
      {si, ci, ki, ex, dm} = {{4{pv}}, pv[4:0], pv[2:0], pv[3:0], pv[1:0]};
      ext_n = ~pv;
      step(2);
      chk({oirq, nirq_n}, rows[i][1:0]);
      chk(breq, pv);
      chk({sr, cr, kr, er, dr}, {{4{pv}}, pv[4:0], pv[2:0], pv[3:0], pv[1:0]});
    end
    ext_n = 8'hFF;
    fl.host_set = 1'b1;
    step(1);
    fl.host_set = 1'b0;
    chk(flag_irq, 1'b1);
    step(4);
    chk(flag_irq, 1'b1);
    fl.cpu_clr = 1'b1;
    step(1);
    fl.cpu_clr = 1'b0;
    chk(flag_irq, 1'b0);
    for (int s = 0; s < 8; s++) begin
      fl.cpu_set = 1'b1;
      fl.bus_sel = s[2:0];
      step(1);
      fl.cpu_set = 1'b0;
      chk(oe_n, 8'(~(8'h01 << s)));
      step(5);
      chk(breq, 8'h01 << s);
      svc = 1'b1;
      step(8);
      svc = 1'b0;
      chk(oe_n, 8'hFF);
    end
    // request never granted, then a cycle never acknowledged
    bs.req = 1'b1;
    step(16);
    bs.clr = 1'b1;
    step(1);
    bs.clr = 1'b0;
    chk(tout, 1'b1);
    bs = 5'h0B;
    step(1);
    chk(tout, 1'b0);
    bs = 5'h04;
    step(16);
    chk(tout, 1'b1);
    bs = 5'h19;
    step(16);
    chk(tout, 1'b0);
    bs = '0;
    pe = 1'b1;
    step(1);
    pe = 1'b0;
    step(5);
    chk(pirq, 1'b1);
    pc = 1'b1;
    step(1);
    pc = 1'b0;
    chk(pirq, 1'b0);
    for (int c = 0; c < 4; c++) begin
      ri = 4'h1 << c;
      step(3);
      chk(rirq, 1'b1);
      rc = 1'b1;
      step(1);
      rc = 1'b0;
      chk(rirq, 1'b0);
    end
    wrap_up;
  end
endmodule
bind bisl_top bisl_top_asserts i_bisl_top_asserts (.mclk, .rst_n, .flag, .bus, .pulse_evt,
  .ring_in, .or_src, .or_jumper, .flag_irq, .bus_irq_oe_n, .timeout_irq, .pulse_irq,
  .ring_irq, .or_irq);
